// file: shared/trip_latch_pkg.sv
// Constants and types shared by the drive trip latch and its input filter.
//
// Summary of operation
// - Any detected trip turns the power output stage off at once.
// - Each trip stays latched until cleared, even after its cause disappears.
// - A detected trip shows as an active alarm on the graphical keypad.
// - The output is never re-enabled while any latched trip remains.
// - A clear request is ignored for a trip whose condition is still active.
// - A keypad stop key press clears inactive trips; the alarm goes once no trip stays latched.
// - In terminal sequencing, a rising edge on application word bit 7 clears.
// - In comms sequencing, a rising edge on network word bit 7 clears.
package trip_latch_pkg;

   localparam int CTRL_WORD_W = 16;
   localparam int RESET_TRIP_BIT = 7;
   localparam int TRIP_COUNT = 8;
   localparam int TRIP_CODE_W = 4;
   localparam logic [TRIP_CODE_W-1:0] NO_TRIP_CODE = 4'hf;
   localparam logic FILTER_RESET_LEVEL = 1'b0;

   typedef enum logic [1:0] {
      SEQ_LOCAL,
      SEQ_TERMINAL,
      SEQ_COMMS
   } seq_mode_e;

endpackage

// file: shared/filter_if.sv
// Carrier between the trip latch and its pin input filter.
`timescale 1ns/1ps
`default_nettype none
interface filter_if #(parameter int WIDTH = 1);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] clean;

   modport filter
   (
      input raw,
      output clean
   );

   modport user
   (
      output raw,
      input clean
   );
endinterface
`default_nettype wire

// file: rtl/pin_filter.sv
// Three-stage synchroniser and agreement filter for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_filter
   import trip_latch_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Filtered pins
   filter_if.filter pins
);

   // ==========================================================
   // Synchroniser stages
   logic [WIDTH-1:0] s1_q, s1_d;
   logic [WIDTH-1:0] s2_q, s2_d;
   logic [WIDTH-1:0] s3_q, s3_d;
   logic [WIDTH-1:0] clean_q, clean_d;

   // A change is accepted only once the second and third stages agree.
   always_comb
   begin
      s1_d = pins.raw;
      s2_d = s1_q;
      s3_d = s2_q;
      clean_d = clean_q;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (s2_q[i] == s3_q[i])
         begin
            clean_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         s1_q <= {WIDTH{FILTER_RESET_LEVEL}};
         s2_q <= {WIDTH{FILTER_RESET_LEVEL}};
         s3_q <= {WIDTH{FILTER_RESET_LEVEL}};
         clean_q <= {WIDTH{FILTER_RESET_LEVEL}};
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         clean_q <= clean_d;
      end
   end

   assign pins.clean = clean_q;

endmodule
`default_nettype wire

// file: rtl/drive_trip_latch_reset.sv
// Trip latch, power stage enable and trip clear control of a motor drive.
`timescale 1ns/1ps
`default_nettype none
module drive_trip_latch_reset
   import trip_latch_pkg::*;
#(
   parameter int N_TRIPS = TRIP_COUNT
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Trip condition pins and keypad
   input wire logic [N_TRIPS-1:0] trip_cond_raw,
   input wire logic stop_key_raw,
   // Sequencing and control words
   input wire seq_mode_e seq_mode,
   input wire logic [CTRL_WORD_W-1:0] app_ctrl_word,
   input wire logic [CTRL_WORD_W-1:0] comms_ctrl_word,
   input wire logic run_request,
   // Power stage and keypad outputs
   output logic power_stage_en,
   output logic [N_TRIPS-1:0] trip_latched,
   output logic graphical_keypad_alarm,
   output logic [TRIP_CODE_W-1:0] graphical_keypad_alarm_code
);

   // ==========================================================
   // Pin filtering
   filter_if #(.WIDTH(N_TRIPS + 1)) pins_if ();

   assign pins_if.raw = {stop_key_raw, trip_cond_raw};

   pin_filter #(.WIDTH(N_TRIPS + 1)) u_pin_filter
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pins(pins_if)
   );

   logic [N_TRIPS-1:0] trip_cond;
   logic stop_key;

   assign trip_cond = pins_if.clean[N_TRIPS-1:0];
   assign stop_key = pins_if.clean[N_TRIPS];

   // ==========================================================
   // Clear request edge detection
   logic stop_prev_q, stop_prev_d;
   logic app_prev_q, app_prev_d;
   logic comms_prev_q, comms_prev_d;
   logic stop_edge, app_edge, comms_edge, clear_req;

   always_comb
   begin
      stop_prev_d = stop_key;
      app_prev_d = app_ctrl_word[RESET_TRIP_BIT];
      comms_prev_d = comms_ctrl_word[RESET_TRIP_BIT];
      stop_edge = stop_key & ~stop_prev_q;
      app_edge = app_ctrl_word[RESET_TRIP_BIT] & ~app_prev_q;
      comms_edge = comms_ctrl_word[RESET_TRIP_BIT] & ~comms_prev_q;
      clear_req = stop_edge;
      if (seq_mode == SEQ_TERMINAL)
      begin
         clear_req = stop_edge | app_edge;
      end
      else if (seq_mode == SEQ_COMMS)
      begin
         clear_req = stop_edge | comms_edge;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         stop_prev_q <= 1'b0;
         app_prev_q <= 1'b1;
         comms_prev_q <= 1'b1;
      end
      else
      begin
         stop_prev_q <= stop_prev_d;
         app_prev_q <= app_prev_d;
         comms_prev_q <= comms_prev_d;
      end
   end

   // ==========================================================
   // Trip latch, power stage and alarm
   logic [N_TRIPS-1:0] latched_q, latched_d;
   logic power_en_q, power_en_d;
   logic alarm_q, alarm_d;
   logic [TRIP_CODE_W-1:0] code_q, code_d;

   always_comb
   begin
      latched_d = latched_q;
      if (clear_req)
      begin
         latched_d = latched_q & trip_cond;
      end
      latched_d = latched_d | trip_cond;
      power_en_d = run_request & ~(|latched_d);
      alarm_d = |latched_d;
      code_d = NO_TRIP_CODE;
      for (int i = N_TRIPS - 1; i >= 0; i--)
      begin
         if (latched_d[i])
         begin
            code_d = TRIP_CODE_W'(i);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         latched_q <= '0;
         power_en_q <= 1'b0;
         alarm_q <= 1'b0;
         code_q <= NO_TRIP_CODE;
      end
      else
      begin
         latched_q <= latched_d;
         power_en_q <= power_en_d;
         alarm_q <= alarm_d;
         code_q <= code_d;
      end
   end

   assign power_stage_en = power_en_q;
   assign trip_latched = latched_q;
   assign graphical_keypad_alarm = alarm_q;
   assign graphical_keypad_alarm_code = code_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_trip_kills_power;
      |trip_cond |=> !power_stage_en;
   endproperty
   a_trip_kills_power: assert property (p_trip_kills_power)
      else $error("Power stage enabled after a trip condition.");

   property p_latch_holds;
      (|latched_q) && !clear_req |=> (latched_q & $past(latched_q)) == $past(latched_q);
   endproperty
   a_latch_holds: assert property (p_latch_holds)
      else $error("Latched trip changed without a clear request.");

   property p_alarm_shown;
      trip_cond[0] |=> graphical_keypad_alarm && graphical_keypad_alarm_code == 4'h0;
   endproperty
   a_alarm_shown: assert property (p_alarm_shown)
      else $error("Alarm not shown for trip zero.");

   property p_no_enable_latched;
      (|trip_latched) |-> !power_stage_en;
   endproperty
   a_no_enable_latched: assert property (p_no_enable_latched)
      else $error("Power stage enabled while a trip is latched.");

   property p_active_not_cleared;
      clear_req && trip_cond[0] |=> trip_latched[0];
   endproperty
   a_active_not_cleared: assert property (p_active_not_cleared)
      else $error("Active trip was cleared.");

   property p_stop_clears;
      stop_edge && trip_cond == '0 |=> trip_latched == '0 && !graphical_keypad_alarm;
   endproperty
   a_stop_clears: assert property (p_stop_clears)
      else $error("Stop key did not clear an inactive trip.");

   property p_terminal_clear;
      seq_mode == SEQ_TERMINAL && app_edge && trip_cond == '0 |=> trip_latched == '0;
   endproperty
   a_terminal_clear: assert property (p_terminal_clear)
      else $error("Application word edge did not clear trips.");

   property p_comms_clear;
      seq_mode == SEQ_COMMS && comms_edge && trip_cond == '0 |=> trip_latched == '0;
   endproperty
   a_comms_clear: assert property (p_comms_clear)
      else $error("Comms word edge did not clear trips.");

   property p_held_bit_no_clear;
      app_ctrl_word[RESET_TRIP_BIT] && $past(app_ctrl_word[RESET_TRIP_BIT]) && !stop_edge
         && !comms_edge && trip_latched[0] |=> trip_latched[0];
   endproperty
   a_held_bit_no_clear: assert property (p_held_bit_no_clear)
      else $error("Held reset bit cleared a trip.");

   property p_alarm_any;
      (|trip_cond) |=> graphical_keypad_alarm && graphical_keypad_alarm_code != NO_TRIP_CODE;
   endproperty
   a_alarm_any: assert property (p_alarm_any)
      else $error("Alarm not shown for a trip condition.");

   property p_active_kept;
      clear_req && (|trip_cond) |=> (trip_latched & $past(trip_cond)) == $past(trip_cond);
   endproperty
   a_active_kept: assert property (p_active_kept)
      else $error("Active trip was dropped by a clear request.");

   property p_app_held_no_clear;
      seq_mode == SEQ_TERMINAL && app_ctrl_word[RESET_TRIP_BIT] && $past(app_ctrl_word[RESET_TRIP_BIT])
         && !stop_edge |=> (trip_latched & $past(trip_latched)) == $past(trip_latched);
   endproperty
   a_app_held_no_clear: assert property (p_app_held_no_clear)
      else $error("Held application reset bit cleared a trip.");

   c_trip_latched: cover property (trip_cond[0] ##1 !trip_cond[0] ##[1:20] trip_latched[0]);
   c_stop_clear: cover property (trip_latched[0] ##1 stop_edge ##1 !trip_latched[0]);
   c_comms_clear: cover property (seq_mode == SEQ_COMMS && comms_edge && trip_latched != '0);
   c_power_back: cover property (!power_stage_en ##1 power_stage_en);
   c_refused_clear: cover property (clear_req && (|trip_cond) && (|latched_q));

endmodule
`default_nettype wire

// file: dv/ctrl_master.sv
// Far-side model of the keypad, the terminal controller and the network master.
`timescale 1ns/1ps
`default_nettype none
module ctrl_master
   import trip_latch_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Clear sources
   output logic stop_key_raw,
   output logic [CTRL_WORD_W-1:0] app_ctrl_word,
   output logic [CTRL_WORD_W-1:0] comms_ctrl_word
);
   initial
   begin
      stop_key_raw = 1'b0;
      app_ctrl_word = 16'h0000;
      comms_ctrl_word = 16'h0000;
   end
   // Holds the key long enough to pass the input filter.
   task automatic press_key();
      @(posedge ref_clk) stop_key_raw <= 1'b1;
      repeat (6) @(posedge ref_clk);
      stop_key_raw <= 1'b0;
   endtask
   // Raises bit 7 of one word with random other bits; hold leaves it high.
   task automatic bit7_edge(input logic comms, input logic hold);
      logic [CTRL_WORD_W-1:0] w;
      w = CTRL_WORD_W'($urandom);
      w[RESET_TRIP_BIT] = 1'b1;
      @(posedge ref_clk);
      if (comms)
         comms_ctrl_word <= w;
      else
         app_ctrl_word <= w;
      repeat (2) @(posedge ref_clk);
      w[RESET_TRIP_BIT] = 1'b0;
      if (!hold && comms)
         comms_ctrl_word <= w;
      if (!hold && !comms)
         app_ctrl_word <= w;
   endtask
endmodule
`default_nettype wire

// file: dv/drive_trip_latch_reset_tb.sv
// Self-checking testbench of the trip latch and its clear control.
`timescale 1ns/1ps
`default_nettype none
module drive_trip_latch_reset_tb;
   import trip_latch_pkg::*;
   logic ref_clk, rst_n, stop_key_raw, run_request, power_stage_en, graphical_keypad_alarm;
   logic [TRIP_COUNT-1:0] trip_cond_raw, trip_latched, e;
   logic [CTRL_WORD_W-1:0] app_ctrl_word, comms_ctrl_word;
   logic [TRIP_CODE_W-1:0] graphical_keypad_alarm_code, code;
   seq_mode_e seq_mode;
   logic [TRIP_COUNT:0] exp_q[$];
   event ev;
   int n_mismatch = 0;
   int n_tests = 0;
   int i, k, s;
   drive_trip_latch_reset #(.N_TRIPS(TRIP_COUNT)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .trip_cond_raw(trip_cond_raw), .stop_key_raw(stop_key_raw), .seq_mode(seq_mode),
      .app_ctrl_word(app_ctrl_word), .comms_ctrl_word(comms_ctrl_word), .run_request(run_request),
      .power_stage_en(power_stage_en), .trip_latched(trip_latched),
      .graphical_keypad_alarm(graphical_keypad_alarm),
      .graphical_keypad_alarm_code(graphical_keypad_alarm_code));
   ctrl_master master (.ref_clk(ref_clk), .stop_key_raw(stop_key_raw),
      .app_ctrl_word(app_ctrl_word), .comms_ctrl_word(comms_ctrl_word));
   task automatic wrap_up();
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Notes the expected latch state once the outputs have settled.
   task automatic expect_lat(input logic [TRIP_COUNT-1:0] lat);
      #1;
      exp_q.push_back({lat, (lat == '0) & run_request});
      ->ev;
   endtask
   task automatic trip(input int idx, input logic on);
      @(posedge ref_clk) trip_cond_raw[idx] <= on;
      repeat (8) @(posedge ref_clk);
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      forever
      begin
         @(ev);
         {e, code[0]} = exp_q.pop_front();
         cmp("power", {7'h00, code[0]}, {7'h00, power_stage_en});
         cmp("latched", e, trip_latched);
         cmp("alarm", {7'h00, e != '0}, {7'h00, graphical_keypad_alarm});
         code = 4'hf;
         for (int b = TRIP_COUNT - 1; b >= 0; b--)
            if (e[b])
               code = b[3:0];
         cmp("code", {4'h0, code}, {4'h0, graphical_keypad_alarm_code});
      end
   end
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      n_mismatch++;
      wrap_up();
   end
   initial
   begin
      s = $urandom(89);
      rst_n = 1'b0;
      trip_cond_raw = '0;
      run_request = 1'b1;
      seq_mode = SEQ_LOCAL;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      expect_lat('0);
      i = $urandom_range(TRIP_COUNT - 1, 0);
      k = (i + 1 + $urandom_range(TRIP_COUNT - 2, 0)) % TRIP_COUNT;
      trip(i, 1'b1);
      expect_lat(8'h01 << i);
      trip(i, 1'b0);
      expect_lat(8'h01 << i);
      trip(k, 1'b1);
      master.press_key();
      repeat (4) @(posedge ref_clk);
      expect_lat(8'h01 << k);
      trip(k, 1'b0);
      master.press_key();
      repeat (4) @(posedge ref_clk);
      expect_lat('0);
      for (int m = 0; m < 3; m++)
      begin
         @(posedge ref_clk) seq_mode <= seq_mode_e'(m);
         trip(i, 1'b1);
         trip(i, 1'b0);
         master.bit7_edge(1'b0, 1'b0);
         repeat (2) @(posedge ref_clk);
         expect_lat(m == 1 ? 8'h00 : 8'h01 << i);
         master.bit7_edge(1'b1, 1'b0);
         repeat (2) @(posedge ref_clk);
         expect_lat(m != 0 ? 8'h00 : 8'h01 << i);
         master.press_key();
         repeat (4) @(posedge ref_clk);
      end
      @(posedge ref_clk) seq_mode <= SEQ_TERMINAL;
      master.bit7_edge(1'b0, 1'b1);
      trip(k, 1'b1);
      trip(k, 1'b0);
      repeat (4) @(posedge ref_clk);
      expect_lat(8'h01 << k);
      master.bit7_edge(1'b0, 1'b0);
      expect_lat(8'h01 << k);
      master.bit7_edge(1'b0, 1'b0);
      repeat (2) @(posedge ref_clk);
      expect_lat('0);
      @(posedge ref_clk) run_request <= 1'b0;
      repeat (2) @(posedge ref_clk);
      expect_lat('0);
      repeat (2) @(posedge ref_clk);
      wrap_up();
   end
endmodule
`default_nettype wire
